/* tmf_consts.svh */
// constants for the timer four block: offsets, fields, resets, codes
`ifndef TMF_CONSTS_SVH
`define TMF_CONSTS_SVH
`define TMF_OFF_CTRL      12'h014
`define TMF_OFF_CMP       12'h018
`define TMF_OFF_STAT      12'h01C
`define TMF_OFF_MASK      12'h020
`define TMF_OFF_DIVSEL    12'h024
`define TMF_OFF_COUNT     12'h028
`define TMF_CTRL_RESET    8'h00
`define TMF_CMP_RESET     8'hFF
`define TMF_MODE_LSB      0
`define TMF_CKSEL_LSB     2
`define TMF_RUN_BIT       5
`define TMF_CK_EXT        3'h7
`define TMF_CK_MAIN       3'h6
`define TMF_CK_SUB8       3'h0
`endif

/* tmf_pkg.sv */
// types shared by the timer four block
package tmf_pkg;
  typedef enum logic [1:0] {
    TMF_MODE_TIMER = 2'b00,
    TMF_MODE_RSVD  = 2'b01,
    TMF_MODE_DIV   = 2'b10,
    TMF_MODE_PWM   = 2'b11
  } tmf_mode_t;
  typedef enum logic [1:0] {
    TMF_PWR_FAST_RUN   = 2'b00,
    TMF_PWR_FAST_IDLE  = 2'b01,
    TMF_PWR_SLOW_RUN   = 2'b10,
    TMF_PWR_SLOW_SLEEP = 2'b11
  } tmf_pwr_t;
endpackage

/* tmf_prescaler.sv */
// free running prescaler giving one-cycle tick enables for timer four
`timescale 1ns/100ps
module tmf_prescaler #(
  parameter int W = 13
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic [W-1:0] stage_tc,
  output logic [W-1:0]      tick
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } tmf_pre_t;
  tmf_pre_t s_r;
  tmf_pre_t s_nxt;

  // ripple count, next value
  always_comb begin
    s_nxt = s_r;
    s_nxt.cnt = s_r.cnt + {{(W-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // tap k pulses once every 2^(k+1) cycles, in the cycle when count bits k:0 are all ones
  genvar k;
  generate
    for (k = 0; k < W; k++) begin : g_tap
      assign tick[k] = stage_tc[k] & (&s_r.cnt[k:0]);
    end
  endgenerate
endmodule

/* tmf_timer.sv */
// timer four: 8-bit up counter with timer, event, divider and pwm modes
//
// Contract
// R01 - software keeps the compare value between 1 and 255
// R02 - mode and clock select stay unchanged when starting, stopping or running
// R03 - clock select picks prescaler tap, main clock, or event pin
// R04 - mode 00 timer/event, 01 reserved, 10 divider output, 11 pwm
// R05 - event counting and pwm only in fast run or fast idle; the code still runs pwm from clock code 000 in slow modes
// R06 - entering oscillator halt clears the run bit
// R07 - control bits 6 and 7 are unimplemented and read undefined
// R08 - compare value not rewritten while running in timer, event, divider
// R09 - main clock above 10 MHz forbids clock code 110
// R10 - sub clock sources not used in fast modes with sub osc stopped
// R11 - each mode accepts only its own set of clock codes
// R12 - run bit 1 starts counting, 0 stops and clears counter
// R13 - control: mode bits 1:0, clock select 4:2, run bit 5
// R14 - timer/event match raises interrupt, clears counter, keeps counting
// R15 - divider match toggles pin, interrupts, clears; pin high when stopped
// R16 - pwm match drives pin low; overflow drives high, interrupts, reloads duty
`timescale 1ns/100ps
`include "tmf_consts.svh"
module tmf_timer
  import tmf_pkg::*;
#(
  parameter int PRE_W = 13
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire tmf_pkg::tmf_pwr_t power_mode,
  input  wire logic             osc_halt,
  input  wire logic             event_pin,
  output logic                  divider_output_pin,
  output logic                  pwm_output_pin,
  output logic                  match_interrupt
);
  import tmf_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] cmp;
    logic [7:0] duty;
    logic [7:0] cnt;
    logic [1:0] divsel;
    logic       stat;
    logic       mask;
    logic       div_pin;
    logic       pwm_pin;
    logic       halt_d;
    logic [2:0] ev_sync;
    logic [31:0] rdata;
  } tmf_state_t;
  tmf_state_t s_r;
  tmf_state_t s_nxt;

  logic [PRE_W-1:0] tick;
  logic             wr_en;
  logic             rd_en;
  logic             src_tick;
  logic             run;
  logic             match;
  logic             match_tick;
  tmf_mode_t        mode;
  logic [2:0]       cksel;
  logic             slow;

  // ==========================================================
  // prescaler taps
  tmf_prescaler #(.W(PRE_W)) u_pre (
    .mclk     (mclk),
    .reset    (reset),
    .stage_tc ({PRE_W{1'b1}}),
    .tick     (tick)
  );

  // tap index for a clock code; divider stage selection shifts by one
  function automatic int tap_of(input logic [2:0] ck, input logic [1:0] dsel);
    int base;
    case (ck)
      3'h0: base = 10;
      3'h1: base = 6;
      3'h2: base = 4;
      3'h3: base = 2;
      3'h4: base = 1;
      default: base = 0;
    endcase
    return base + int'(dsel[0]);
  endfunction

  // ==========================================================
  // field decode
  assign run   = s_r.ctrl[`TMF_RUN_BIT]; // R13
  assign mode  = tmf_mode_t'(s_r.ctrl[`TMF_MODE_LSB +: 2]); // R13
  assign cksel = s_r.ctrl[`TMF_CKSEL_LSB +: 3]; // R13
  assign slow  = (power_mode == TMF_PWR_SLOW_RUN) || (power_mode == TMF_PWR_SLOW_SLEEP);

  // source select; slow modes only see the sub clock divided by eight
  always_comb begin
    if (slow) begin
      src_tick = (cksel == `TMF_CK_SUB8) ? tick[PRE_W-1] : 1'b0; // R03
    end else if (cksel == `TMF_CK_EXT) begin
      src_tick = s_r.ev_sync[1] & ~s_r.ev_sync[2]; // R03
    end else if (cksel == `TMF_CK_MAIN) begin
      src_tick = s_r.divsel[1] ? tick[0] : 1'b1; // R03
    end else begin
      src_tick = tick[tap_of(cksel, s_r.divsel)]; // R03
    end
  end

  // events count on the pin's rise; the match is judged on the following fall
  assign match_tick = (!slow && cksel == `TMF_CK_EXT) ? (s_r.ev_sync[2] & ~s_r.ev_sync[1]) : src_tick; // R14
  assign match = (s_r.cnt == s_r.duty);

  // ==========================================================
  // apb access, zero wait states
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = s_r.rdata;
  assign match_interrupt = s_r.stat & s_r.mask;

  // ==========================================================
  // next state
  always_comb begin
    logic ev;
    logic ovf;
    ev = 1'b0;
    ovf = 1'b0;
    s_nxt = s_r;
    s_nxt.ev_sync = {s_r.ev_sync[1], s_r.ev_sync[0], event_pin};
    s_nxt.halt_d = osc_halt;
    // register writes
    if (wr_en) begin
      if (paddr == `TMF_OFF_CTRL) begin
        s_nxt.ctrl = {2'b00, pwdata[5:0]}; // R07
        if (pwdata[`TMF_RUN_BIT] && !run) begin
          s_nxt.duty = s_r.cmp; // R16
        end
      end else if (paddr == `TMF_OFF_CMP) begin
        s_nxt.cmp = pwdata[7:0];
      end else if (paddr == `TMF_OFF_STAT) begin
        if (pwdata[0]) begin
          s_nxt.stat = 1'b0;
        end
      end else if (paddr == `TMF_OFF_MASK) begin
        s_nxt.mask = pwdata[0];
      end else if (paddr == `TMF_OFF_DIVSEL) begin
        s_nxt.divsel = pwdata[1:0];
      end
    end
    // timer/event/divider read compare directly; pwm uses the shadow
    if (mode != TMF_MODE_PWM) begin
      s_nxt.duty = s_nxt.cmp;
    end
    if (!s_nxt.ctrl[`TMF_RUN_BIT]) begin
      s_nxt.cnt = 8'h00; // R12
      s_nxt.div_pin = 1'b1; // R15
      s_nxt.pwm_pin = 1'b1; // R16
    end else if (run && (src_tick || (match_tick && mode == TMF_MODE_TIMER))) begin
      case (mode)
        TMF_MODE_TIMER: begin
          if (match_tick && match) begin
            s_nxt.cnt = 8'h00; // R14
            ev = 1'b1; // R14
          end else if (src_tick) begin
            s_nxt.cnt = s_r.cnt + 8'h01;
          end
        end
        TMF_MODE_DIV: begin
          if (match) begin
            s_nxt.cnt = 8'h00; // R15
            s_nxt.div_pin = ~s_r.div_pin; // R15
            ev = 1'b1; // R15
          end else begin
            s_nxt.cnt = s_r.cnt + 8'h01;
          end
        end
        TMF_MODE_PWM: begin
          ovf = (s_r.cnt == 8'hFF);
          s_nxt.cnt = s_r.cnt + 8'h01;
          if (ovf) begin
            s_nxt.pwm_pin = 1'b1; // R16
            s_nxt.duty = s_nxt.cmp; // R16
            ev = 1'b1; // R16
          end else if (match) begin
            s_nxt.pwm_pin = 1'b0; // R16
          end
        end
        default: begin
          s_nxt.cnt = s_r.cnt; // R04
        end
      endcase
    end
    // oscillator halt entry stops the timer
    if (osc_halt && !s_r.halt_d) begin
      s_nxt.ctrl[`TMF_RUN_BIT] = 1'b0; // R06
      s_nxt.cnt = 8'h00;
      s_nxt.div_pin = 1'b1;
      s_nxt.pwm_pin = 1'b1;
    end
    // set wins over a clear in the same cycle
    if (ev) begin
      s_nxt.stat = 1'b1;
    end
    // read data latched in setup phase, unmapped reads zero
    if (rd_en) begin
      if (paddr == `TMF_OFF_CTRL) begin
        s_nxt.rdata = {24'h0, s_r.ctrl}; // R07
      end else if (paddr == `TMF_OFF_CMP) begin
        s_nxt.rdata = {24'h0, s_r.cmp};
      end else if (paddr == `TMF_OFF_STAT) begin
        s_nxt.rdata = {31'h0, s_r.stat};
      end else if (paddr == `TMF_OFF_MASK) begin
        s_nxt.rdata = {31'h0, s_r.mask};
      end else if (paddr == `TMF_OFF_DIVSEL) begin
        s_nxt.rdata = {30'h0, s_r.divsel};
      end else if (paddr == `TMF_OFF_COUNT) begin
        s_nxt.rdata = {24'h0, s_r.cnt};
      end else begin
        s_nxt.rdata = 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_r <= '0;
      s_r.ctrl <= `TMF_CTRL_RESET;
      s_r.cmp <= `TMF_CMP_RESET;
      s_r.duty <= `TMF_CMP_RESET;
      s_r.div_pin <= 1'b1;
      s_r.pwm_pin <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign divider_output_pin = s_r.div_pin;
  assign pwm_output_pin     = s_r.pwm_pin;

  // ==========================================================
  // checks
  property p_halt_stops;
    @(posedge mclk) disable iff (reset)
      $rose(osc_halt) |=> !s_r.ctrl[`TMF_RUN_BIT];
  endproperty
  a_halt_stops: assert property (p_halt_stops) else $error("run bit not cleared on halt"); // R06

  property p_stop_clears;
    @(posedge mclk) disable iff (reset)
      !run |-> (s_r.cnt == 8'h00 && divider_output_pin && pwm_output_pin);
  endproperty
  a_stop_clears: assert property (p_stop_clears) else $error("stopped timer not idle"); // R12

  property p_tmr_match;
    @(posedge mclk) disable iff (reset)
      (run && mode == TMF_MODE_TIMER && match_tick && match && !wr_en && !osc_halt)
        |=> (s_r.cnt == 8'h00 && s_r.stat);
  endproperty
  a_tmr_match: assert property (p_tmr_match) else $error("timer match not handled"); // R14

  property p_div_toggle;
    @(posedge mclk) disable iff (reset)
      (run && mode == TMF_MODE_DIV && src_tick && match && !wr_en && !osc_halt)
        |=> (divider_output_pin != $past(divider_output_pin));
  endproperty
  a_div_toggle: assert property (p_div_toggle) else $error("divider pin did not toggle"); // R15

  property p_pwm_ovf;
    @(posedge mclk) disable iff (reset)
      (run && mode == TMF_MODE_PWM && src_tick && s_r.cnt == 8'hFF && !wr_en && !osc_halt)
        |=> (pwm_output_pin && s_r.stat && s_r.cnt == 8'h00);
  endproperty
  a_pwm_ovf: assert property (p_pwm_ovf) else $error("pwm overflow not handled"); // R16

  property p_ctrl_hi_zero;
    @(posedge mclk) disable iff (reset)
      s_r.ctrl[7:6] == 2'b00;
  endproperty
  a_ctrl_hi_zero: assert property (p_ctrl_hi_zero) else $error("unused control bits set"); // R07

  property p_rsvd_hold;
    @(posedge mclk) disable iff (reset)
      (run && mode == TMF_MODE_RSVD && !wr_en && !osc_halt) |=> $stable(s_r.cnt);
  endproperty
  a_rsvd_hold: assert property (p_rsvd_hold) else $error("reserved mode counted"); // R04

  property p_irq_level;
    @(posedge mclk) disable iff (reset)
      match_interrupt |-> (s_r.mask && s_r.stat);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt without cause"); // R14
endmodule

/* tmf_pulse_src.sv */
// partner model: external event pulse source driving the timer four event pin
`timescale 1ns/100ps
module tmf_pulse_src (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       fire,
  input  wire logic [3:0] count,
  output logic            event_pin,
  output logic            busy
);
  logic [3:0] left_r;
  logic [3:0] ph_r;
  // ==========================================
  // pulse train
  // each pulse is 8 cycles high then 8 low, well above the minimum pin width
  always_ff @(posedge mclk) begin
    if (reset) begin
      left_r    <= 4'h0;
      ph_r      <= 4'h0;
      event_pin <= 1'b0;
    end else if (fire && left_r == 4'h0) begin
      left_r <= count;
      ph_r   <= 4'h0;
    end else if (left_r != 4'h0) begin
      ph_r      <= ph_r + 4'h1;
      event_pin <= ~ph_r[3];
      if (ph_r == 4'hF) begin
        left_r <= left_r - 4'h1;
      end
    end
  end
  assign busy = (left_r != 4'h0);
endmodule

/* timer_four_control_config_tb.sv */
// self-checking bench for the timer four block
`timescale 1ns/100ps
`include "tmf_consts.svh"
module timer_four_control_config_tb;
  import tmf_pkg::*;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        osc_halt = 1'b0;
  logic        fire = 1'b0;
  logic [3:0]  count = 4'h0;
  tmf_pwr_t    power_mode = TMF_PWR_FAST_RUN; // event and pwm only in fast modes
  logic [31:0] prdata;
  logic [31:0] q;
  logic        pready, pslverr, event_pin, busy, div_pin, pwm_pin, irq;
  int          bad_count = 0;
  int          total_checks = 0;
  int          n;
  always #25 mclk = ~mclk;
  tmf_timer dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .power_mode(power_mode), .osc_halt(osc_halt),
    .event_pin(event_pin), .divider_output_pin(div_pin), .pwm_output_pin(pwm_pin),
    .match_interrupt(irq));
  tmf_pulse_src src (.mclk(mclk), .reset(reset), .fire(fire), .count(count),
    .event_pin(event_pin), .busy(busy));
  // ==========================================
  // helpers
  task automatic tally_and_finish;
    if (bad_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // apb master: request held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    chk("pready", 32'h1, {31'h0, pready});
    chk("pslverr", 32'h0, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
    #1; // let the write land before callers look at outputs
  endtask
  function automatic logic sig(input int s);
    return (s == 0) ? div_pin : (s == 1) ? pwm_pin : irq;
  endfunction
  task automatic wait_sig(input int s, input logic v, input int lim);
    int k;
    k = 0;
    while (sig(s) !== v && k < lim) begin
      @(posedge mclk);
      #1;
      k++;
    end
    chk("pin wait", {31'h0, v}, {31'h0, sig(s)});
  endtask
  task automatic pulses(input logic [3:0] c);
    @(posedge mclk);
    count <= c;
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (busy && n < 500);
    chk("pulse done", 32'h0, {31'h0, busy});
    repeat (6) @(posedge mclk); // synchroniser latency
  endtask
  // measures one low phase of the pwm pin, in clock cycles
  task automatic low_len(input int lo, input int hi);
    n = 0;
    while (pwm_pin === 1'b0 && n < 600) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("pwm low len", 32'h1, {31'h0, (n >= lo && n <= hi)});
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    xfer(0, `TMF_OFF_CTRL, 0);
    chk("ctrl reset", 32'h0, q);
    xfer(0, `TMF_OFF_CMP, 0);
    chk("cmp reset", 32'hFF, q);
    chk("idle pins", 32'h3, {30'h0, div_pin, pwm_pin});
    chk("idle irq", 32'h0, {31'h0, irq});
    xfer(0, 12'h100, 0);
    chk("unmapped", 32'h0, q);
  endtask
  task automatic t_ctrl;
    xfer(1, `TMF_OFF_CTRL, 32'hDE);
    xfer(0, `TMF_OFF_CTRL, 0);
    chk("ctrl fields", 32'h1E, q & 32'h3F);
    xfer(1, `TMF_OFF_CTRL, 32'h0);
  endtask
  task automatic t_event;
    xfer(1, `TMF_OFF_MASK, 32'h1);
    xfer(1, `TMF_OFF_CMP, 32'h3);
    xfer(1, `TMF_OFF_CTRL, 32'h1C);
    xfer(1, `TMF_OFF_CTRL, 32'h3C);
    pulses(4'h2);
    xfer(0, `TMF_OFF_STAT, 0);
    chk("stat early", 32'h0, q & 32'h1);
    pulses(4'h1);
    xfer(0, `TMF_OFF_STAT, 0);
    chk("stat match", 32'h1, q & 32'h1);
    chk("irq match", 32'h1, {31'h0, irq});
    xfer(0, `TMF_OFF_COUNT, 0);
    chk("count clr", 32'h0, q);
    xfer(1, `TMF_OFF_MASK, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    xfer(1, `TMF_OFF_MASK, 32'h1);
    xfer(1, `TMF_OFF_STAT, 32'h1);
    chk("irq w1c", 32'h0, {31'h0, irq});
    pulses(4'h1);
    xfer(0, `TMF_OFF_COUNT, 0);
    chk("count on", 32'h1, q);
    xfer(1, `TMF_OFF_CTRL, 32'h1C);
    xfer(0, `TMF_OFF_COUNT, 0);
    chk("count stop", 32'h0, q);
  endtask
  task automatic t_div;
    xfer(1, `TMF_OFF_CTRL, 32'h02);
    xfer(1, `TMF_OFF_CMP, 32'h1);
    xfer(1, `TMF_OFF_CTRL, 32'h22);
    wait_sig(0, 1'b0, 12000);
    wait_sig(0, 1'b1, 12000);
    xfer(0, `TMF_OFF_STAT, 0);
    chk("div stat", 32'h1, q & 32'h1);
    wait_sig(0, 1'b0, 12000);
    xfer(1, `TMF_OFF_CTRL, 32'h02);
    wait_sig(0, 1'b1, 4);
    xfer(1, `TMF_OFF_STAT, 32'h1);
  endtask
  // reserved mode, the slow run power mode and the divider stage select
  task automatic t_slow;
    xfer(1, `TMF_OFF_CMP, 32'hFF);
    xfer(1, `TMF_OFF_CTRL, 32'h0D);
    xfer(1, `TMF_OFF_CTRL, 32'h2D);
    repeat (64) @(posedge mclk);
    xfer(0, `TMF_OFF_COUNT, 0);
    chk("rsvd count", 32'h0, q);
    xfer(1, `TMF_OFF_CTRL, 32'h0D);
    xfer(1, `TMF_OFF_CTRL, 32'h0C);
    @(posedge mclk);
    power_mode <= TMF_PWR_SLOW_RUN;
    xfer(1, `TMF_OFF_CTRL, 32'h2C);
    repeat (64) @(posedge mclk);
    xfer(0, `TMF_OFF_COUNT, 0);
    chk("slow tap count", 32'h0, q);
    xfer(1, `TMF_OFF_CTRL, 32'h0C);
    xfer(1, `TMF_OFF_CTRL, 32'h00);
    xfer(1, `TMF_OFF_CTRL, 32'h20);
    repeat (8200) @(posedge mclk);
    xfer(0, `TMF_OFF_COUNT, 0);
    chk("slow sub count", 32'h1, {31'h0, (q >= 1 && q <= 2)});
    xfer(1, `TMF_OFF_CTRL, 32'h00);
    xfer(1, `TMF_OFF_CTRL, 32'h0C);
    @(posedge mclk);
    power_mode <= TMF_PWR_FAST_RUN;
    xfer(1, `TMF_OFF_CTRL, 32'h2C);
    repeat (64) @(posedge mclk);
    xfer(0, `TMF_OFF_COUNT, 0);
    chk("fast tap count", 32'h1, {31'h0, (q >= 7 && q <= 10)});
    xfer(1, `TMF_OFF_CTRL, 32'h0C);
    xfer(1, `TMF_OFF_DIVSEL, 32'h1);
    xfer(1, `TMF_OFF_CTRL, 32'h2C);
    repeat (64) @(posedge mclk);
    xfer(0, `TMF_OFF_COUNT, 0);
    chk("half tap count", 32'h1, {31'h0, (q >= 3 && q <= 6)});
    xfer(1, `TMF_OFF_CTRL, 32'h0C);
    xfer(1, `TMF_OFF_DIVSEL, 32'h0);
  endtask
  task automatic t_pwm;
    xfer(1, `TMF_OFF_CMP, 32'h80);
    xfer(1, `TMF_OFF_CTRL, 32'h17);
    xfer(1, `TMF_OFF_CTRL, 32'h37);
    wait_sig(1, 1'b0, 600);
    wait_sig(1, 1'b1, 600);
    xfer(1, `TMF_OFF_STAT, 32'h1);
    xfer(1, `TMF_OFF_CMP, 32'h40);
    wait_sig(1, 1'b0, 600);
    low_len(253, 259);
    xfer(0, `TMF_OFF_STAT, 0);
    chk("pwm ovf stat", 32'h1, q & 32'h1);
    wait_sig(1, 1'b0, 600);
    low_len(380, 388);
    @(posedge mclk);
    osc_halt <= 1'b1;
    repeat (3) @(posedge mclk);
    xfer(0, `TMF_OFF_CTRL, 0);
    chk("halt run", 32'h0, q & 32'h20);
    wait_sig(1, 1'b1, 260);
    @(posedge mclk);
    osc_halt <= 1'b0;
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    t_reset();
    t_ctrl();
    t_event();
    t_div();
    t_slow();
    t_pwm();
    tally_and_finish();
  end
  initial begin
    repeat (80000) @(posedge mclk);
    bad_count++;
    tally_and_finish();
  end
endmodule
